// *** common/schc_pkg.sv ***
// Shared constants, register map and types for the smart card host control block
package schc_pkg;
    // Register byte offsets
    localparam logic [7:0] SCHC_REG_CTRL = 8'h00;
    localparam logic [7:0] SCHC_REG_STATUS = 8'h04;
    localparam logic [7:0] SCHC_REG_DIVTAB = 8'h08;
    // Control register field positions
    localparam int SCHC_CTRL_CMD_POS = 0;
    localparam int SCHC_CTRL_RST_POS = 1;
    localparam int SCHC_CTRL_VSA_POS = 2;
    localparam int SCHC_CTRL_VSB_POS = 3;
    localparam int SCHC_CTRL_DVA_POS = 4;
    localparam int SCHC_CTRL_DVB_POS = 5;
    // Status register field positions
    localparam int SCHC_ST_CARD_PRESENCE_IN_POS = 0;
    localparam int SCHC_ST_ACT_POS = 1;
    localparam int SCHC_ST_OVL_POS = 2;
    localparam int SCHC_ST_UV_POS = 3;
    localparam int SCHC_ST_INT_POS = 4;
    localparam int SCHC_ST_VOLT_POS = 8;
    localparam int SCHC_ST_DIV_POS = 12;
    // Reset values: command inactive (high), divide table 1,2,4,8 by select code
    localparam logic [31:0] SCHC_CTRL_RST = 32'h0000_0001;
    localparam logic [7:0] SCHC_DIVTAB_RST = 8'he4;
    // Debounce time in microseconds and its cycle count at 100 MHz
    localparam int SCHC_CLK_MHZ = 100;
    localparam int SCHC_DEBOUNCE_US = 8000;
    localparam int SCHC_DEBOUNCE_CYC = SCHC_DEBOUNCE_US * SCHC_CLK_MHZ;
    // Sequencer step spacing in cycles
    localparam int SCHC_STEP_CYC = 16;
    // AXI responses
    localparam logic [1:0] SCHC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCHC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SCHC_V_OFF,
        SCHC_V_1V8,
        SCHC_V_3V,
        SCHC_V_5V
    } schc_volt_t;

    // One two-way pin drive: output, output enable
    typedef struct packed {
        logic o;
        logic oe;
    } schc_pin_drv_t;

    // Card-side contacts driven by the block
    typedef struct packed {
        schc_volt_t supply;
        logic reset;
        logic clock;
    } schc_card_out_t;
endpackage

// *** rtl/schc_clk_div.sv ***
// Card clock divider: ratio 1, 2, 4 or 8 from the external clock
`timescale 1ns/1ps
module schc_clk_div
    import schc_pkg::*;
#(
    parameter int CNT_W = 3
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic en,
    input wire logic [1:0] ratio_log2,
    // Divided clock
    output logic clk_out
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] half;
    logic clk_ff;

    // Toggle period in source cycles; ratio 1 is handled by passing the source clock
    always_comb begin
        half = CNT_W'((1 << ratio_log2) >> 1);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            cnt_ff <= '0;
            clk_ff <= 1'b0;
        end else if (cnt_ff + CNT_W'(1) >= half) begin
            cnt_ff <= '0;
            clk_ff <= ~clk_ff;
        end else begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end

    // Divide by one gates the source clock itself; keeps full rate through a plain AND with the enable, not a glitch-safe gate
    assign clk_out = !en ? 1'b0 : (ratio_log2 == 2'd0) ? (aclk & en) : clk_ff;
endmodule

// *** rtl/schc_top.sv ***
// Smart card host control: activation sequencer, pin pass-through and AXI4-Lite registers
`timescale 1ns/1ps

// Summary of operation
// - Select a low: 5 V or 3 V; select a high: 1.8 V or 3 V.
// - Activation command is active low; low requests activation, high withdraws it.
// - Activation starts only on a falling command edge with a card present.
// - Interrupt output goes low while a card is present.
// - Interrupt output also goes low on card supply overload.
// - Card reset contact follows the control register reset bit once the sequence is active.
// - All card pins are disabled while host supply is undervoltage.
// - Clock ratio chosen from the two divider select bits together.
// - Data line passes both ways between host pin and card contact.
// - Both auxiliary lines pass both ways between host pin and card contact.
// - Undriven host-side lines rest high-impedance with a weak pull-up.
// - Card clock is derived from the clock input through the divider.
// - Ratios available are divide by one, two, four and eight.
// - Card is treated as present only after about 8 ms debounce.
module schc_top
    import schc_pkg::*;
#(
    parameter int DEBOUNCE_CYC = SCHC_DEBOUNCE_CYC,
    parameter int STEP_CYC = SCHC_STEP_CYC
) (
    // Clock and reset (aclk is the external card clock source)
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Card detection and supply status pins
    input wire logic card_presence_in_n,
    input wire logic card_presence_in,
    input wire logic supply_overload,
    input wire logic host_undervolt,
    // Interrupt to host
    output logic irq_n,
    // Card supply, reset and clock contacts
    output schc_volt_t card_supply_out,
    output logic card_reset_contact,
    output logic card_clock_contact,
    // Host-side data and auxiliary lines
    input wire logic [2:0] host_line_i,
    output logic [2:0] host_line_o,
    output logic [2:0] host_line_oe,
    // Card-side data and auxiliary contacts
    input wire logic [2:0] card_line_i,
    output logic [2:0] card_line_o,
    output logic [2:0] card_line_oe
);
    typedef enum logic [2:0] {
        SCHC_S_IDLE,
        SCHC_S_PWR,
        SCHC_S_IO,
        SCHC_S_CLK,
        SCHC_S_ACTIVE,
        SCHC_S_DEACT
    } schc_seq_t;

    localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
    localparam int ST_W = $clog2(STEP_CYC + 1);

    logic [31:0] ctrl_ff;
    logic [7:0] divtab_ff;
    logic [2:0] card_presence_in_a_ff, card_presence_in_b_ff, ovl_ff, uv_ff;
    logic card_presence_in_raw, card_presence_in_ff, ovl, uv;
    logic [DB_W-1:0] db_cnt_ff;
    logic cmd_n, cmd_prev_ff, cmd_fall;
    schc_seq_t state_ff;
    logic [ST_W-1:0] step_ff;
    logic step_done;
    logic fault;
    logic [1:0] div_code, ratio_log2;
    logic clk_en, clk_div;
    schc_volt_t volt_sel;
    logic active_pins;
    logic [2:0] host_oe_ff, card_oe_ff;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [31:0] status;

    // Three-stage capture of asynchronous pins; act once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_presence_in_a_ff <= 3'h7;
            card_presence_in_b_ff <= 3'h0;
            ovl_ff <= 3'h0;
            uv_ff <= 3'h7;
        end else begin
            card_presence_in_a_ff <= {card_presence_in_a_ff[1:0], card_presence_in_n};
            card_presence_in_b_ff <= {card_presence_in_b_ff[1:0], card_presence_in};
            ovl_ff <= {ovl_ff[1:0], supply_overload};
            uv_ff <= {uv_ff[1:0], host_undervolt};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovl <= 1'b0;
            uv <= 1'b1;
        end else begin
            if (ovl_ff[2] == ovl_ff[1]) ovl <= ovl_ff[2];
            if (uv_ff[2] == uv_ff[1]) uv <= uv_ff[2];
        end
    end

    // Either presence input can report the card
    assign card_presence_in_raw = (card_presence_in_a_ff[2] == card_presence_in_a_ff[1] && !card_presence_in_a_ff[2]) ||
                      (card_presence_in_b_ff[2] == card_presence_in_b_ff[1] && card_presence_in_b_ff[2]);

    // Insertion must be stable for the debounce time; removal is taken at once
    always_ff @(posedge aclk) begin
        if (!aresetn || !card_presence_in_raw) begin
            db_cnt_ff <= '0;
            card_presence_in_ff <= 1'b0;
        end else if (db_cnt_ff >= DB_W'(DEBOUNCE_CYC - 1)) begin
            card_presence_in_ff <= 1'b1;
        end else begin
            db_cnt_ff <= db_cnt_ff + DB_W'(1);
        end
    end

    // Command sits in a register, so it is same-domain and needs no synchroniser
    assign cmd_n = ctrl_ff[SCHC_CTRL_CMD_POS];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_prev_ff <= 1'b1;
        end else begin
            cmd_prev_ff <= cmd_n;
        end
    end
    assign cmd_fall = cmd_prev_ff && !cmd_n;

    assign fault = ovl || uv || !card_presence_in_ff;
    assign step_done = step_ff >= ST_W'(STEP_CYC - 1);

    // Activation: supply, then I/O, then clock; deactivation drops all of them together in SCHC_S_DEACT
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= SCHC_S_IDLE;
            step_ff <= '0;
        end else begin
            step_ff <= step_done ? '0 : step_ff + ST_W'(1);
            case (state_ff)
                SCHC_S_IDLE: begin
                    step_ff <= '0;
                    if (cmd_fall && card_presence_in_ff && !ovl && !uv) begin
                        state_ff <= SCHC_S_PWR;
                    end
                end
                SCHC_S_PWR, SCHC_S_IO, SCHC_S_CLK: begin
                    if (fault || cmd_n) begin
                        state_ff <= SCHC_S_DEACT;
                        step_ff <= '0;
                    end else if (step_done) begin
                        state_ff <= schc_seq_t'(state_ff + 3'd1);
                    end
                end
                SCHC_S_ACTIVE: begin
                    if (fault || cmd_n) begin
                        state_ff <= SCHC_S_DEACT;
                        step_ff <= '0;
                    end
                end
                SCHC_S_DEACT: begin
                    if (step_done) state_ff <= SCHC_S_IDLE;
                end
                default: state_ff <= SCHC_S_IDLE;
            endcase
        end
    end

    // Supply voltage from the two select bits
    always_comb begin
        case ({ctrl_ff[SCHC_CTRL_VSA_POS], ctrl_ff[SCHC_CTRL_VSB_POS]})
            2'b00: volt_sel = SCHC_V_3V;
            2'b01: volt_sel = SCHC_V_5V;
            2'b10: volt_sel = SCHC_V_3V;
            2'b11: volt_sel = SCHC_V_1V8;
            default: volt_sel = SCHC_V_3V;
        endcase
    end

    // Mapping of select code to ratio is a software table of 2-bit log2 entries
    assign div_code = {ctrl_ff[SCHC_CTRL_DVB_POS], ctrl_ff[SCHC_CTRL_DVA_POS]};
    assign ratio_log2 = divtab_ff[2*div_code +: 2];

    assign clk_en = (state_ff == SCHC_S_CLK || state_ff == SCHC_S_ACTIVE) && !uv;

    schc_clk_div #(
        .CNT_W(3)
    ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(clk_en),
        .ratio_log2(ratio_log2),
        .clk_out(clk_div)
    );

    // Card pins inactive outside the active window and whenever host supply is low
    assign active_pins = (state_ff == SCHC_S_IO || state_ff == SCHC_S_CLK ||
                          state_ff == SCHC_S_ACTIVE) && !uv;

    assign card_supply_out = (state_ff != SCHC_S_IDLE && state_ff != SCHC_S_DEACT && !uv) ?
                             volt_sel : SCHC_V_OFF;
    assign card_reset_contact = (state_ff == SCHC_S_ACTIVE && !uv) ?
                                ctrl_ff[SCHC_CTRL_RST_POS] : 1'b0;
    assign card_clock_contact = clk_div;

    // Open-drain pass-through: the side that pulls low first owns the line until it lets go.
    // Latching the direction stops the two drivers from chasing each other combinationally.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_oe_ff <= 3'h0;
            card_oe_ff <= 3'h0;
        end else begin
            host_oe_ff <= {3{active_pins}} & ~card_line_i & ~card_oe_ff;
            card_oe_ff <= {3{active_pins}} & ~host_line_i & ~host_oe_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_line
            assign card_line_o[g] = 1'b0;
            assign card_line_oe[g] = active_pins && card_oe_ff[g];
            assign host_line_o[g] = 1'b0;
            // Released lines float to the weak pull-up outside this logic
            assign host_line_oe[g] = active_pins && host_oe_ff[g];
        end
    endgenerate

    // Interrupt while a card is present or the supply is overloaded
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(card_presence_in_ff || ovl);
        end
    end

    assign status = {16'h0000, 2'h0, ratio_log2, 2'h0, volt_sel, 3'h0, !irq_n, uv, ovl,
                     state_ff == SCHC_S_ACTIVE, card_presence_in_ff};

    // AXI4-Lite write: address and data taken in any order, response after both
    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_ff && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SCHC_RESP_OKAY;
            ctrl_ff <= SCHC_CTRL_RST;
            divtab_ff <= SCHC_DIVTAB_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (aw_ff && w_ff) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= SCHC_RESP_OKAY;
                case (awaddr_ff & 8'hfc)
                    SCHC_REG_CTRL: begin
                        if (wstrb_ff[0]) ctrl_ff[7:0] <= {2'h0, wdata_ff[5:0]};
                    end
                    SCHC_REG_DIVTAB: begin
                        if (wstrb_ff[0]) divtab_ff <= wdata_ff[7:0];
                    end
                    SCHC_REG_STATUS: ;
                    default: s_axi_bresp <= SCHC_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SCHC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= SCHC_RESP_OKAY;
            case (s_axi_araddr & 8'hfc)
                SCHC_REG_CTRL: s_axi_rdata <= ctrl_ff;
                SCHC_REG_STATUS: s_axi_rdata <= status;
                SCHC_REG_DIVTAB: s_axi_rdata <= {24'h000000, divtab_ff};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= SCHC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// *** tb/schc_top_sva.sv ***
// Concurrent checks on the card and host sides of the smart card host control block
`timescale 1ns/1ps
module schc_top_sva
    import schc_pkg::*;
#(
    parameter int DEBOUNCE_CYC = SCHC_DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Status pins and interrupt
    input wire logic card_presence_in_n,
    input wire logic card_presence_in,
    input wire logic supply_overload,
    input wire logic host_undervolt,
    input wire logic irq_n,
    // Card contacts
    input wire schc_volt_t card_supply_out,
    input wire logic card_reset_contact,
    input wire logic card_clock_contact,
    // Open-drain lines
    input wire logic [2:0] host_line_i,
    input wire logic [2:0] host_line_oe,
    input wire logic [2:0] card_line_i,
    input wire logic [2:0] card_line_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [15:0] card_presence_in_cnt_ff;
    logic [15:0] nxt_card_presence_in_cnt;
    // Saturates so a long session never wraps back under the debounce time
    assign nxt_card_presence_in_cnt = (card_presence_in_cnt_ff == 16'hffff) ? card_presence_in_cnt_ff : card_presence_in_cnt_ff + 16'h1;
    always_ff @(posedge aclk) begin
        if (!aresetn || (card_presence_in_n && !card_presence_in)) begin
            card_presence_in_cnt_ff <= 16'h0;
        end else begin
            card_presence_in_cnt_ff <= nxt_card_presence_in_cnt;
        end
    end

    sequence power_on;
        $past(card_supply_out) == SCHC_V_OFF && card_supply_out != SCHC_V_OFF;
    endsequence

    chk_irq_overload: assert property (
        supply_overload [*6] |-> !irq_n && card_supply_out == SCHC_V_OFF)
        else $error("overload left irq high or supply on");
    chk_irq_idle: assert property (
        (card_presence_in_n && !card_presence_in && !supply_overload) [*8] |-> irq_n)
        else $error("irq low with no cause");
    chk_debounce_max: assert property (
        card_presence_in_cnt_ff == DEBOUNCE_CYC + 8 |-> !irq_n)
        else $error("irq late after insertion");
    chk_debounce_min: assert property (
        $fell(irq_n) && !supply_overload |-> card_presence_in_cnt_ff >= DEBOUNCE_CYC)
        else $error("irq before debounce time");
    chk_act_present: assert property (
        power_on |-> card_presence_in_cnt_ff >= DEBOUNCE_CYC)
        else $error("supply on without settled card");
    chk_undervolt_off: assert property (
        host_undervolt [*6] |-> card_supply_out == SCHC_V_OFF && card_line_oe == 3'h0
            && !card_clock_contact && !card_reset_contact)
        else $error("card pins live in undervoltage");
    chk_removal_off: assert property (
        (card_presence_in_n && !card_presence_in) [*6] |-> card_supply_out == SCHC_V_OFF)
        else $error("supply on after removal");
    chk_pins_need_supply: assert property (
        card_reset_contact || card_clock_contact || card_line_oe != 3'h0
            |-> card_supply_out != SCHC_V_OFF)
        else $error("card pin active with supply off");
    chk_clk_late: assert property (
        power_on |=> !card_clock_contact [*7])
        else $error("card clock too soon after power");
    chk_rst_late: assert property (
        power_on |=> !card_reset_contact [*8])
        else $error("card reset too soon after power");
    chk_card_cause: assert property (
        (card_line_oe & host_line_i & $past(host_line_i) & $past(host_line_i, 2)) == 3'h0)
        else $error("card line pulled with host line high");
    chk_host_cause: assert property (
        (host_line_oe & card_line_i & $past(card_line_i) & $past(card_line_i, 2)) == 3'h0)
        else $error("host line pulled with card line high");

    cov_power_on: cover property (power_on);
    cov_overload: cover property (supply_overload && !irq_n);
    cov_to_host: cover property (host_line_oe != 3'h0);
endmodule

bind schc_top schc_top_sva #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_sva (.*);

// *** tb/schc_card_model.sv ***
// Behavioural smart card: open-drain contacts and a card clock edge counter
`timescale 1ns/1ps
module schc_card_model
    import schc_pkg::*;
(
    // Contacts from the block
    input wire schc_volt_t card_supply_out,
    input wire logic card_clock_contact,
    input wire logic [2:0] card_line_oe,
    // Scenario control: card pulls its contacts low
    input wire logic [2:0] card_pull,
    // Resolved contact levels and clock edge count
    output logic [2:0] card_line_i,
    output int clk_edges
);
    // Pull-up goes to the card supply, so unpowered contacts read low
    assign card_line_i = (card_supply_out == SCHC_V_OFF) ? 3'h0 : ~(card_line_oe | card_pull);
    initial clk_edges = 0;
    always @(posedge card_clock_contact) clk_edges <= clk_edges + 1;
endmodule

// *** tb/test_smart_card_host_control.sv ***
// Self-checking bench for the smart card host control block
`timescale 1ns/1ps
module test_smart_card_host_control
    import schc_pkg::*;
();
    localparam int DEB = 20;
    localparam int STEP = 4;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic card_presence_in_n, card_presence_in, supply_overload, host_undervolt, irq_n;
    schc_volt_t card_supply_out;
    logic card_reset_contact, card_clock_contact;
    logic [2:0] host_line_i, host_line_o, host_line_oe, host_pull;
    logic [2:0] card_line_i, card_line_o, card_line_oe, card_pull;
    int clk_edges, bad_count, checks_done, i, e;
    typedef struct packed {
        logic [3:0] sel;
        schc_volt_t volt;
        logic [5:0] edges;
    } schc_row_t;
    // Selects {div b, div a, volt b, volt a}, supply, card clock edges in 32 cycles
    schc_row_t rows [4] = '{'{4'h2, SCHC_V_5V, 6'h20}, '{4'h4, SCHC_V_3V, 6'h10},
                            '{4'hb, SCHC_V_1V8, 6'h08}, '{4'hd, SCHC_V_3V, 6'h04}};

    schc_top #(.DEBOUNCE_CYC(DEB), .STEP_CYC(STEP)) DUT (.*);
    schc_card_model u_card (.*);
    assign host_line_i = ~(host_line_oe | host_pull);

    always #5 aclk = ~aclk;

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        bad_count++;
        $display("wrong value at %0t: %s", $time, m);
    endtask

    // Takes the condition as evaluated at the call, just after the edge; counts and reports it at mid-cycle, then resumes on the edge
    task automatic chk(input logic ok, input string m);
        @(negedge aclk);
        checks_done++;
        if (ok !== 1'b1) fail(m);
        @(posedge aclk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic [1:0] rsp);
        int n;
        logic ta, tw, done;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        done = 1'b0;
        for (n = 0; n < 40 && !done; n++) begin
            // Handshakes read mid-cycle hold the value that the next edge samples
            @(negedge aclk);
            ta = wr ? s_axi_awready : s_axi_arready;
            tw = s_axi_wready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!done) begin
            fail("bus hang");
            give_verdict();
        end
    endtask

    task automatic ctrl(input logic [5:0] v);
        bus(1'b1, SCHC_REG_CTRL, {26'h0, v}, q, r);
    endtask

    task automatic act;
        for (e = 0; e < 100 && card_reset_contact !== 1'b1; e++) @(posedge aclk);
        chk(card_reset_contact === 1'b1, "no activation");
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {card_presence_in_n, card_presence_in, supply_overload, host_undervolt} = 4'h8;
        host_pull = 3'h0;
        card_pull = 3'h0;
        bad_count = 0;
        checks_done = 0;
        cyc(2);
        aresetn <= 1'b1;
        card_presence_in_n <= 1'b0;
        cyc(DEB / 2);
        chk(irq_n === 1'b1, "irq before debounce");
        cyc(DEB);
        chk(irq_n === 1'b0, "no irq for card");
        for (i = 0; i < 4; i++) begin
            ctrl({rows[i].sel, 2'h3});
            cyc(4 * STEP);
            chk(card_supply_out === SCHC_V_OFF, "supply after withdraw");
            ctrl({rows[i].sel, 2'h2});
            act();
            chk(card_supply_out === rows[i].volt, "supply level");
            bus(1'b0, SCHC_REG_STATUS, 32'h0, q, r);
            chk(q[SCHC_ST_ACT_POS] === 1'b1 && q[SCHC_ST_CARD_PRESENCE_IN_POS] === 1'b1 &&
                q[SCHC_ST_VOLT_POS +: 2] === rows[i].volt, "status word");
            e = clk_edges;
            cyc(32);
            e = clk_edges - e;
            chk(e >= rows[i].edges - 1 && e <= rows[i].edges + 1, "clock ratio");
            host_pull[i % 3] <= 1'b1;
            cyc(6);
            chk(card_line_i[i % 3] === 1'b0, "line to card");
            host_pull <= 3'h0;
            card_pull[i % 3] <= 1'b1;
            cyc(6);
            chk(host_line_i[i % 3] === 1'b0, "line to host");
            card_pull <= 3'h0;
            cyc(6);
            chk((host_line_i & card_line_i) === 3'h7, "lines not resting high");
        end
        ctrl(6'h00);
        cyc(4);
        chk(card_reset_contact === 1'b0, "reset contact level");
        host_undervolt <= 1'b1;
        cyc(8);
        chk(card_supply_out === SCHC_V_OFF && card_line_oe === 3'h0, "undervolt");
        host_undervolt <= 1'b0;
        cyc(4 * STEP);
        chk(card_supply_out === SCHC_V_OFF, "restart without edge");
        ctrl(6'h03);
        ctrl(6'h02);
        act();
        card_presence_in_n <= 1'b1;
        cyc(8);
        chk(irq_n === 1'b1 && card_supply_out === SCHC_V_OFF, "removal");
        ctrl(6'h03);
        ctrl(6'h02);
        cyc(4 * STEP);
        chk(card_supply_out === SCHC_V_OFF, "start with no card");
        card_presence_in <= 1'b1;
        cyc(DEB + 10);
        chk(irq_n === 1'b0 && card_supply_out === SCHC_V_OFF, "second input");
        ctrl(6'h03);
        ctrl(6'h02);
        act();
        supply_overload <= 1'b1;
        cyc(8);
        chk(card_supply_out === SCHC_V_OFF, "supply on in overload");
        card_presence_in <= 1'b0;
        cyc(8);
        chk(irq_n === 1'b0, "no irq for overload");
        supply_overload <= 1'b0;
        cyc(8);
        chk(irq_n === 1'b1, "irq stuck");
        bus(1'b0, 8'h0c, 32'h0, q, r);
        chk(r === SCHC_RESP_SLVERR && q === 32'h0, "unmapped read");
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        bus(1'b0, SCHC_REG_CTRL, 32'h0, q, r);
        chk(q === SCHC_CTRL_RST, "control reset value");
        bus(1'b0, SCHC_REG_DIVTAB, 32'h0, q, r);
        chk(q[7:0] === SCHC_DIVTAB_RST, "divider table reset value");
        give_verdict();
    end
endmodule
